//--- rtl/ebu_pkg.sv
/*
  constants and types for the external bus cycle sequencer:
  register offsets, field positions, reset values and phase states.
  assumes a 32-bit ahb-lite register bus and a 16-bit external data bus.
*/
package ebu_pkg;
  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] ADDR_OFS = 8'h04;
  localparam logic [7:0] WDATA_OFS = 8'h08;
  localparam logic [7:0] STATUS_OFS = 8'h0c;
  localparam logic [7:0] TCFG0_OFS = 8'h10;
  localparam logic [7:0] TCFG1_OFS = 8'h14;
  ////////////////////////////////////////////////////////////////////////////
  // control register fields
  localparam int CTRL_START = 0;
  localparam int CTRL_WRITE = 1;
  localparam int CTRL_MUX = 2;
  localparam int CTRL_CS = 3;
  localparam int CTRL_BHE = 4;
  localparam int CTRL_BUS_REFERENCE_CLOCK_OUT = 5;
  // status register fields
  localparam int STATUS_BUSY = 0;
  localparam int STATUS_RDATA_LSB = 16;
  ////////////////////////////////////////////////////////////////////////////
  // chip_select_timing_config fields
  localparam int TC_AB = 0;
  localparam int TC_ABX_LSB = 1;
  localparam int TC_CMD_LSB = 3;
  localparam int TC_WSU = 5;
  localparam int TC_ACC_LSB = 6;
  localparam int TC_HOLD_LSB = 11;
  localparam int TC_RDY_EN = 13;
  localparam int TC_RDY_POL = 14;
  localparam int TC_RDY_ASYNC = 15;
  localparam int TCFG_W = 16;
  localparam logic [15:0] TCFG_RST = 16'h00c0;
  ////////////////////////////////////////////////////////////////////////////
  localparam int NUM_CS = 2;
  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam int CNT_W = 6;
  localparam logic [23:0] ADDR_RST = 24'h00_0000;
  localparam logic [15:0] DATA_RST = 16'h0000;

  typedef enum logic [2:0] {
    idle,
    address_setup_phase,
    command_delay_phase,
    write_setup_turnaround_phase,
    access_phase,
    ready_wait,
    hold_phase
  } phase_t;
endpackage

//--- rtl/external_bus_cycle_timing.sv
/*
  external bus cycle sequencer with ahb-lite register slave.
  assumes hclk for registers, bus_clk (the bus system clock) for the pins,
  and an external module that meets setup/hold against bus_clk.
*/
// Functional notes
// - five phases run in fixed order
// - phase lengths come from per-select config
// - setup 1-2 cycles, plus 0-3 on window change
// - command 0-3, turnaround 0-1, access 1-32, hold 0-3
// - third phase is write setup or mux turnaround
// - ready stretches access when enabled
// - read data captured as read strobe rises
// - later address change cannot corrupt captured data
// - reference clock is bus clock, driver enabled
// - ready polarity is configurable
// - asynchronous ready adds a stage and wait
// - inactive ready waits, active ready ends access
`timescale 1ns/100ps
module external_bus_cycle_timing (
  input wire logic hclk, // register bus clock
  input wire logic hresetn, // asynchronous reset, active low
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write when high
  input wire logic [2:0] hsize, // transfer size, words only
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready
  output logic [31:0] hrdata, // read data
  output logic hreadyout, // slave ready
  output logic hresp, // always okay
  input wire logic bus_clk, // external bus system clock
  output logic bus_reference_clock_out, // reference clock to the module
  output logic [23:0] addr_out, // external address
  input wire logic [15:0] data_in, // data pins, input side
  output logic [15:0] data_out, // data pins, output side
  output logic data_oe_n, // data pin enable, low drives
  output logic ale, // address latch enable
  output logic rd_n, // read strobe
  output logic wr_n, // write strobe
  output logic [1:0] cs_n, // chip selects
  output logic byte_high_enable_n, // upper byte enable
  input wire logic ready_in // ready handshake pin
);
  ////////////////////////////////////////////////////////////////////////////
  // register domain
  logic sel_q, sel_d, wr_q, wr_d;
  logic [7:0] a_q, a_d;
  logic [31:0] hrdata_q, hrdata_d;
  logic write_q, write_d, mux_q, mux_d, cs_q, cs_d, bhe_q, bhe_d;
  logic bus_reference_clock_out_en_q, bus_reference_clock_out_en_d, busy_q, busy_d, req_q, req_d;
  logic [23:0] addr_q, addr_d;
  logic [15:0] wdata_q, wdata_d, rdata_q, rdata_d;
  logic [15:0] tcfg_q [ebu_pkg::NUM_CS];
  logic [15:0] tcfg_d [ebu_pkg::NUM_CS];
  logic ack_s1, ack_s2, ack_s3;
  logic ack_q;
  logic [15:0] link_rdata_q;

  function automatic logic [31:0] read_word(input logic [7:0] ofs);
    logic [31:0] w;
    w = 32'h0000_0000;
    unique case (ofs)
      ebu_pkg::CTRL_OFS: begin
        w[ebu_pkg::CTRL_WRITE] = write_q;
        w[ebu_pkg::CTRL_MUX] = mux_q;
        w[ebu_pkg::CTRL_CS] = cs_q;
        w[ebu_pkg::CTRL_BHE] = bhe_q;
        w[ebu_pkg::CTRL_BUS_REFERENCE_CLOCK_OUT] = bus_reference_clock_out_en_q;
      end
      ebu_pkg::ADDR_OFS: w[23:0] = addr_q;
      ebu_pkg::WDATA_OFS: w[15:0] = wdata_q;
      ebu_pkg::STATUS_OFS: begin
        w[ebu_pkg::STATUS_BUSY] = busy_q;
        w[ebu_pkg::STATUS_RDATA_LSB +: 16] = rdata_q;
      end
      ebu_pkg::TCFG0_OFS: w[15:0] = tcfg_q[0];
      ebu_pkg::TCFG1_OFS: w[15:0] = tcfg_q[1];
      default: w = 32'h0000_0000;
    endcase
    return w;
  endfunction

  always_comb begin
    sel_d = 1'b0;
    wr_d = wr_q;
    a_d = a_q;
    hrdata_d = hrdata_q;
    {write_d, mux_d, cs_d, bhe_d, bus_reference_clock_out_en_d} = {write_q, mux_q, cs_q, bhe_q, bus_reference_clock_out_en_q};
    busy_d = busy_q;
    req_d = req_q;
    addr_d = addr_q;
    wdata_d = wdata_q;
    rdata_d = rdata_q;
    tcfg_d = tcfg_q;
    // completion crossing back from the bus domain
    if (ack_s2 ^ ack_s3) begin
      busy_d = 1'b0;
      rdata_d = link_rdata_q;
    end
    // settings are frozen while a cycle runs, so the bus domain reads them stable
    if (sel_q && wr_q && !busy_q) begin
      unique case (a_q)
        ebu_pkg::CTRL_OFS: begin
          write_d = hwdata[ebu_pkg::CTRL_WRITE];
          mux_d = hwdata[ebu_pkg::CTRL_MUX];
          cs_d = hwdata[ebu_pkg::CTRL_CS];
          bhe_d = hwdata[ebu_pkg::CTRL_BHE];
          bus_reference_clock_out_en_d = hwdata[ebu_pkg::CTRL_BUS_REFERENCE_CLOCK_OUT];
          if (hwdata[ebu_pkg::CTRL_START]) begin
            busy_d = 1'b1;
            req_d = ~req_q;
          end
        end
        ebu_pkg::ADDR_OFS: addr_d = hwdata[23:0];
        ebu_pkg::WDATA_OFS: wdata_d = hwdata[15:0];
        ebu_pkg::TCFG0_OFS: tcfg_d[0] = hwdata[15:0];
        ebu_pkg::TCFG1_OFS: tcfg_d[1] = hwdata[15:0];
        default: ;
      endcase
    end
    if (hsel && hready && htrans[1]) begin
      sel_d = 1'b1;
      wr_d = hwrite;
      a_d = haddr[7:0];
      if (!hwrite) begin
        hrdata_d = read_word(haddr[7:0]);
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sel_q <= 1'b0;
      wr_q <= 1'b0;
      a_q <= 8'h00;
      hrdata_q <= 32'h0000_0000;
      {write_q, mux_q, cs_q, bhe_q, bus_reference_clock_out_en_q} <= 5'h00;
      busy_q <= 1'b0;
      req_q <= 1'b0;
      addr_q <= ebu_pkg::ADDR_RST;
      wdata_q <= ebu_pkg::DATA_RST;
      rdata_q <= ebu_pkg::DATA_RST;
      tcfg_q <= '{default: ebu_pkg::TCFG_RST};
      {ack_s1, ack_s2, ack_s3} <= 3'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      sel_q <= sel_d;
      wr_q <= wr_d;
      a_q <= a_d;
      hrdata_q <= hrdata_d;
      {write_q, mux_q, cs_q, bhe_q, bus_reference_clock_out_en_q} <= {write_d, mux_d, cs_d, bhe_d, bus_reference_clock_out_en_d};
      busy_q <= busy_d;
      req_q <= req_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      rdata_q <= rdata_d;
      tcfg_q <= tcfg_d;
      {ack_s1, ack_s2, ack_s3} <= {ack_q, ack_s1, ack_s2};
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  assign hrdata = hrdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // bus domain
  logic lrst_a, lrst_n;
  logic req_s1, req_s2, req_s3, rdy_s1, rdy_s2, rdy_s3, clk_s1, clk_s2;
  ebu_pkg::phase_t ph_q, ph_d, nxt;
  logic [5:0] cnt_q, cnt_d;
  logic last_cs_q, last_cs_d, win_valid_q, win_valid_d, ack_d;
  logic [15:0] link_rdata_d;
  logic [15:0] cfg;
  logic rdy_raw, rdy_act;
  logic [5:0] ab_len;
  logic [23:0] addr_out_d;
  logic [15:0] data_out_d;
  logic data_oe_n_d, ale_d, rd_n_d, wr_n_d, bhe_n_d;
  logic [1:0] cs_n_d;

  // bus clock forwarded with its driver enabled; gated only by a synced level
  assign bus_reference_clock_out = bus_clk & clk_s2;

  always_ff @(posedge bus_clk or negedge hresetn) begin
    if (!hresetn) begin
      lrst_a <= 1'b0;
      lrst_n <= 1'b0;
    end else begin
      lrst_a <= 1'b1;
      lrst_n <= lrst_a;
    end
  end

  // settings stay frozen while busy, so reading them here is safe
  assign cfg = tcfg_q[cs_q];
  assign rdy_raw = cfg[ebu_pkg::TC_RDY_ASYNC] ? rdy_s3 : rdy_s2;
  assign rdy_act = (rdy_raw == cfg[ebu_pkg::TC_RDY_POL]);

  always_comb begin
    ab_len = {5'h00, 1'b1} + {5'h00, cfg[ebu_pkg::TC_AB]};
    if (!win_valid_q || last_cs_q != cs_q) begin
      ab_len = ab_len + {4'h0, cfg[ebu_pkg::TC_ABX_LSB +: 2]};
    end
  end

  function automatic logic [5:0] phase_len(input ebu_pkg::phase_t s);
    unique case (s)
      ebu_pkg::address_setup_phase: return ab_len;
      ebu_pkg::command_delay_phase: return {4'h0, cfg[ebu_pkg::TC_CMD_LSB +: 2]};
      ebu_pkg::write_setup_turnaround_phase: return {5'h00, cfg[ebu_pkg::TC_WSU]};
      ebu_pkg::access_phase: return {1'b0, cfg[ebu_pkg::TC_ACC_LSB +: 5]} + 6'h01;
      ebu_pkg::hold_phase: return {4'h0, cfg[ebu_pkg::TC_HOLD_LSB +: 2]};
      default: return 6'h01;
    endcase
  endfunction

  // zero-length phases are skipped, order is never changed
  function automatic ebu_pkg::phase_t after(input ebu_pkg::phase_t s);
    unique case (s)
      ebu_pkg::address_setup_phase:
        return (phase_len(ebu_pkg::command_delay_phase) != 6'h00) ? ebu_pkg::command_delay_phase :
          (phase_len(ebu_pkg::write_setup_turnaround_phase) != 6'h00) ?
          ebu_pkg::write_setup_turnaround_phase : ebu_pkg::access_phase;
      ebu_pkg::command_delay_phase:
        return (phase_len(ebu_pkg::write_setup_turnaround_phase) != 6'h00) ?
          ebu_pkg::write_setup_turnaround_phase : ebu_pkg::access_phase;
      ebu_pkg::write_setup_turnaround_phase: return ebu_pkg::access_phase;
      ebu_pkg::access_phase, ebu_pkg::ready_wait:
        return (phase_len(ebu_pkg::hold_phase) != 6'h00) ? ebu_pkg::hold_phase : ebu_pkg::idle;
      default: return ebu_pkg::idle;
    endcase
  endfunction

  always_comb begin
    ph_d = ph_q;
    cnt_d = cnt_q;
    last_cs_d = last_cs_q;
    win_valid_d = win_valid_q;
    link_rdata_d = link_rdata_q;
    nxt = after(ph_q);
    unique case (ph_q)
      ebu_pkg::idle: begin
        if (req_s2 ^ req_s3) begin
          ph_d = ebu_pkg::address_setup_phase;
          cnt_d = ab_len - 6'h01;
          last_cs_d = cs_q;
          win_valid_d = 1'b1;
        end
      end
      ebu_pkg::access_phase: begin
        if (cnt_q != 6'h00) begin
          cnt_d = cnt_q - 6'h01;
        end else if (cfg[ebu_pkg::TC_RDY_EN] &&
                     (cfg[ebu_pkg::TC_RDY_ASYNC] || !rdy_act)) begin
          ph_d = ebu_pkg::ready_wait;
        end else begin
          ph_d = nxt;
          cnt_d = phase_len(nxt) - 6'h01;
          if (!write_q) begin
            link_rdata_d = data_in;
          end
        end
      end
      ebu_pkg::ready_wait: begin
        if (rdy_act) begin
          ph_d = nxt;
          cnt_d = phase_len(nxt) - 6'h01;
          if (!write_q) begin
            link_rdata_d = data_in;
          end
        end
      end
      default: begin
        if (cnt_q != 6'h00) begin
          cnt_d = cnt_q - 6'h01;
        end else begin
          ph_d = nxt;
          cnt_d = phase_len(nxt) - 6'h01;
        end
      end
    endcase
    ack_d = ack_q ^ (ph_d == ebu_pkg::idle && ph_q != ebu_pkg::idle);
  end

  // pin values follow the phase being entered, so they change with it
  always_comb begin
    cs_n_d = 2'h3;
    if (ph_d != ebu_pkg::idle) begin
      cs_n_d[cs_q] = 1'b0;
    end
    ale_d = mux_q && ph_d == ebu_pkg::address_setup_phase;
    rd_n_d = !(!write_q && (ph_d == ebu_pkg::access_phase || ph_d == ebu_pkg::ready_wait));
    wr_n_d = !(write_q && (ph_d == ebu_pkg::access_phase || ph_d == ebu_pkg::ready_wait));
    bhe_n_d = !(bhe_q && ph_d != ebu_pkg::idle);
    addr_out_d = (ph_d == ebu_pkg::address_setup_phase) ? addr_q : addr_out;
    data_out_d = data_out;
    data_oe_n_d = 1'b1;
    if (mux_q && ph_d == ebu_pkg::address_setup_phase) begin
      data_out_d = addr_q[15:0];
      data_oe_n_d = 1'b0;
    end else if (write_q && ph_d != ebu_pkg::idle && ph_d != ebu_pkg::address_setup_phase &&
                 ph_d != ebu_pkg::command_delay_phase) begin
      data_out_d = wdata_q;
      data_oe_n_d = 1'b0;
    end
  end

  always_ff @(posedge bus_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      {req_s1, req_s2, req_s3} <= 3'h0;
      {rdy_s1, rdy_s2, rdy_s3} <= 3'h0;
      {clk_s1, clk_s2} <= 2'h0;
      ph_q <= ebu_pkg::idle;
      cnt_q <= 6'h00;
      last_cs_q <= 1'b0;
      win_valid_q <= 1'b0;
      ack_q <= 1'b0;
      link_rdata_q <= ebu_pkg::DATA_RST;
      addr_out <= ebu_pkg::ADDR_RST;
      data_out <= ebu_pkg::DATA_RST;
      data_oe_n <= 1'b1;
      ale <= 1'b0;
      rd_n <= 1'b1;
      wr_n <= 1'b1;
      cs_n <= 2'h3;
      byte_high_enable_n <= 1'b1;
    end else begin
      {req_s1, req_s2, req_s3} <= {req_q, req_s1, req_s2};
      {rdy_s1, rdy_s2, rdy_s3} <= {ready_in, rdy_s1, rdy_s2};
      {clk_s1, clk_s2} <= {bus_reference_clock_out_en_q, clk_s1};
      ph_q <= ph_d;
      cnt_q <= cnt_d;
      last_cs_q <= last_cs_d;
      win_valid_q <= win_valid_d;
      ack_q <= ack_d;
      link_rdata_q <= link_rdata_d;
      addr_out <= addr_out_d;
      data_out <= data_out_d;
      data_oe_n <= data_oe_n_d;
      ale <= ale_d;
      rd_n <= rd_n_d;
      wr_n <= wr_n_d;
      cs_n <= cs_n_d;
      byte_high_enable_n <= bhe_n_d;
    end
  end
endmodule

//--- verification/ebu_props.sv
/*
  pin-level checker for the external bus cycle sequencer.
  assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/100ps
module ebu_props (
  input wire logic hresetn, // async reset, active low
  input wire logic bus_clk, // bus system clock
  input wire logic bus_reference_clock_out, // gated reference clock
  input wire logic [23:0] addr_out, // external address
  input wire logic data_oe_n, // data enable, low drives
  input wire logic ale, // address latch enable
  input wire logic rd_n, // read strobe
  input wire logic wr_n, // write strobe
  input wire logic [1:0] cs_n, // chip selects
  input wire logic byte_high_enable_n // upper byte enable
);
  default clocking @(posedge bus_clk); endclocking
  default disable iff (!hresetn);
  ////////////////////////////////////////////////////////////////////////////
  a_strobes_apart: assert property (rd_n || wr_n)
    else $error("read and write strobes low together");
  a_strobe_in_cycle: assert property (!(rd_n && wr_n) |-> cs_n != 2'h3)
    else $error("strobe low without a chip select");
  a_bhe_in_cycle: assert property (!byte_high_enable_n |-> cs_n != 2'h3)
    else $error("byte enable outside a cycle");
  a_one_select: assert property (cs_n != 2'h0)
    else $error("both chip selects low");
  a_ale_setup_only: assert property (ale |-> rd_n && wr_n && !data_oe_n)
    else $error("latch enable outside address drive");
  a_ale_length: assert property ($rose(ale) |-> ##[1:5] !ale)
    else $error("address setup longer than five cycles");
  a_write_drives: assert property (!wr_n |-> !data_oe_n)
    else $error("write strobe without data driven");
  a_read_releases: assert property (!rd_n |-> data_oe_n)
    else $error("data lines driven during read");
  a_addr_steady: assert property (!rd_n && $past(!rd_n) |-> $stable(addr_out))
    else $error("address moved inside read strobe");
  // the reference clock is a gated copy, so it is low whenever bus_clk is
  a_refclk_gated: assert property (!bus_reference_clock_out)
    else $error("reference clock high while bus clock low");
endmodule

bind external_bus_cycle_timing ebu_props u_ebu_props (.hresetn, .bus_clk,
  .bus_reference_clock_out, .addr_out, .data_oe_n, .ale, .rd_n, .wr_n, .cs_n,
  .byte_high_enable_n);

//--- verification/ext_mem_model.sv
/*
  behavioural memory on the external bus, with a ready handshake.
  assumes strobes and address come from the device's reference clock domain.
*/
`timescale 1ns/100ps
module ext_mem_model (
  input wire logic ref_clk, // reference clock from the device
  input wire logic [1:0] cs_n, // chip selects
  input wire logic rd_n, // read strobe
  input wire logic wr_n, // write strobe
  input wire logic [23:0] addr_out, // address
  input wire logic [15:0] data_out, // device write data
  output logic [15:0] data_in, // read data to the device
  output logic ready_in, // ready handshake
  input wire logic [5:0] rdy_wait, // strobe cycles before ready
  input wire logic rdy_pol // active level of ready
);
  logic [15:0] mem [16];
  logic [15:0] last_q = 16'h0000;
  logic rdy_q = 1'b0;
  logic [5:0] low_cnt = 6'h00;
  wire logic sel = cs_n != 2'h3;
  initial for (int i = 0; i < 16; i++) mem[i] = 16'h3c00 ^ 16'(i);
  // released lines show the inverse, so a late capture cannot pass by luck
  assign data_in = (sel && !rd_n) ? mem[addr_out[3:0]] : ~last_q;
  assign ready_in = rdy_q ? rdy_pol : !rdy_pol;
  always @(posedge ref_clk) begin
    if (sel && !wr_n) mem[addr_out[3:0]] <= data_out;
    if (sel && !rd_n) last_q <= mem[addr_out[3:0]];
    low_cnt <= (rd_n && wr_n) ? 6'h00 : low_cnt + 6'h01;
    // ready moves only on the reference clock and drops with the strobe
    rdy_q <= !(rd_n && wr_n) && (low_cnt + 6'h01 >= rdy_wait);
  end
endmodule

//--- verification/external_bus_cycle_timing_test.sv
/*
  register-level tests of the bus cycle sequencer against a memory model.
  assumes the package, design, model and checker are compiled first.
*/
`timescale 1ns/100ps
module external_bus_cycle_timing_test;
  logic hclk = 1'b0;
  logic bus_clk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata;
  logic hready, hreadyout, hresp, refclk, data_oe_n, ale, rd_n, wr_n, bhe_n, ready_in;
  logic [2:0] hsize;
  logic [23:0] addr_out;
  logic [15:0] data_in, data_out;
  logic [1:0] cs_n;
  logic [5:0] rdy_wait = 6'h00;
  logic rdy_pol = 1'b1;
  int mismatches = 0;
  int checked = 0;
  int rd_lo, wr_lo, ale_hi;
  assign hready = hreadyout;
  assign hsize = 3'h2;

  external_bus_cycle_timing u_external_bus_cycle_timing (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .bus_clk(bus_clk), .bus_reference_clock_out(refclk), .addr_out(addr_out),
    .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n), .ale(ale), .rd_n(rd_n),
    .wr_n(wr_n), .cs_n(cs_n), .byte_high_enable_n(bhe_n), .ready_in(ready_in));
  ext_mem_model u_ext_mem_model (.ref_clk(refclk), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
    .addr_out(addr_out), .data_out(data_out), .data_in(data_in), .ready_in(ready_in),
    .rdy_wait(rdy_wait), .rdy_pol(rdy_pol));

  initial forever #25 hclk = ~hclk;
  initial begin
    #7;
    forever #16 bus_clk = ~bus_clk;
  end
  always @(posedge bus_clk) begin
    rd_lo += !rd_n;
    wr_lo += !wr_n;
    ale_hi += ale;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic ahb(input logic wr, input logic [7:0] ofs, input logic [31:0] wd,
      output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h00_0000, ofs};
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rd_chk(input logic [7:0] ofs, input logic [31:0] exp);
    logic [31:0] st;
    ahb(1'b0, ofs, 32'h0000_0000, st);
    check(st, exp);
    check({30'h0000_0000, hreadyout, hresp}, 32'h0000_0002);
  endtask
  // one full bus cycle: program timing, start, poll busy, then judge lengths and data
  task automatic run_case(input logic [31:0] ctl, input logic [15:0] tcfg,
      input logic [23:0] a, input logic [15:0] wd, input int e_ale, input int e_str,
      input logic exact);
    logic [31:0] st;
    int n;
    ahb(1'b1, ctl[3] ? ebu_pkg::TCFG1_OFS : ebu_pkg::TCFG0_OFS, {16'h0000, tcfg}, st);
    ahb(1'b1, ebu_pkg::ADDR_OFS, {8'h00, a}, st);
    ahb(1'b1, ebu_pkg::WDATA_OFS, {16'h0000, wd}, st);
    rd_lo = 0;
    wr_lo = 0;
    ale_hi = 0;
    ahb(1'b1, ebu_pkg::CTRL_OFS, ctl, st);
    st = 32'h0000_0001;
    for (n = 0; n < 300 && st[0] !== 1'b0; n++) ahb(1'b0, ebu_pkg::STATUS_OFS, 32'h0, st);
    check(st[0], 1'b0);
    check(ale_hi, e_ale);
    n = ctl[1] ? wr_lo : rd_lo;
    check(exact ? n : 32'(n >= e_str), exact ? e_str : 1);
    if (ctl[1]) check(u_ext_mem_model.mem[a[3:0]], wd);
    else check(st[31:16], 16'h3c00 ^ {12'h000, a[3:0]});
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (4) @(posedge hclk);
    rd_chk(ebu_pkg::TCFG0_OFS, 32'h0000_00c0);
    rd_chk(ebu_pkg::TCFG1_OFS, 32'h0000_00c0);
    rd_chk(ebu_pkg::STATUS_OFS, 32'h0000_0000);
    rd_chk(8'h18, 32'h0000_0000);
    run_case(32'h0000_0025, 16'h0005, 24'h00_0003, 16'h0000, 4, 1, 1'b1);
    run_case(32'h0000_0025, 16'h0005, 24'h00_0004, 16'h0000, 2, 1, 1'b1);
    run_case(32'h0000_0029, 16'h1fd8, 24'h12_0007, 16'h0000, 0, 32, 1'b1);
    run_case(32'h0000_0025, 16'h0005, 24'h00_0008, 16'h0000, 4, 1, 1'b1);
    run_case(32'h0000_0033, 16'h0060, 24'h00_0005, 16'ha5c3, 0, 2, 1'b1);
    run_case(32'h0000_0027, 16'h0020, 24'h00_0006, 16'h5a3c, 1, 1, 1'b1);
    rdy_wait <= 6'h06;
    run_case(32'h0000_0029, 16'h6000, 24'h00_0009, 16'h0000, 0, 6, 1'b0);
    rdy_wait <= 6'h00;
    rdy_pol <= 1'b0;
    run_case(32'h0000_0029, 16'ha000, 24'h00_000a, 16'h0000, 0, 2, 1'b0);
    close_out();
  end
  initial begin
    #2000000;
    mismatches++;
    close_out();
  end
endmodule
